// File: verilog/sdram_mode_ctrl.sv
// Mode register decode, DLL-off read timing and APB access for the DRAM
//
// The implementer's own choices: the APB slave port and the register addresses.
`include "sdram_mode_consts.svh"

module sdram_mode_ctrl #(
    parameter int ADDR_W = 13,
    parameter int BURST_CK = `BURST_CK
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // DRAM clock and command pins
    input wire logic DRAM_CK_IN,
    input wire logic DRAM_CKE_IN,
    input wire logic DRAM_CS_N_IN,
    input wire logic DRAM_RAS_N_IN,
    input wire logic DRAM_CAS_N_IN,
    input wire logic DRAM_WE_N_IN,
    input wire logic [2:0] DRAM_BA_IN,
    input wire logic [12:0] DRAM_ADDR_IN,
    // APB slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // Data path controls
    output logic DRV_EN_OUT,
    output logic [15:0] DQ_OUT,
    output logic PATTERN_SEL_OUT,
    output logic [1:0] CAL_LOC_OUT,
    output logic DYN_TERM_EN_OUT,
    output logic SR_EXT_RATE_OUT,
    output logic DLL_ENABLE_OUT,
    output logic [4:0] WRITE_LATENCY_OUT
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (ADDR_W != 13)
    begin : g_addr_check
        $error("sdram_mode_ctrl needs a 13 bit address bus");
    end
    if (BURST_CK < 1 || BURST_CK > 7)
    begin : g_burst_check
        $error("sdram_mode_ctrl BURST_CK must be 1 to 7");
    end

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_mode_set(input sdram_mode_pkg::dram_cmd_t c,
                                         input logic [1:0] sel);
        is_mode_set = !c.cs_n && !c.ras_n && !c.cas_n && !c.we_n
            && c.ba == {1'b0, sel};
    endfunction

    function automatic logic is_read(input sdram_mode_pkg::dram_cmd_t c);
        is_read = !c.cs_n && c.ras_n && !c.cas_n && c.we_n;
    endfunction

    function automatic logic is_sr_entry(input sdram_mode_pkg::dram_cmd_t c);
        is_sr_entry = !c.cs_n && !c.ras_n && !c.cas_n && c.we_n && !c.cke;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    sdram_mode_pkg::dram_cmd_t pin_raw;
    sdram_mode_pkg::dram_cmd_t pin;
    logic ck_sync;

    assign pin_raw.cke = DRAM_CKE_IN;
    assign pin_raw.cs_n = DRAM_CS_N_IN;
    assign pin_raw.ras_n = DRAM_RAS_N_IN;
    assign pin_raw.cas_n = DRAM_CAS_N_IN;
    assign pin_raw.we_n = DRAM_WE_N_IN;
    assign pin_raw.ba = DRAM_BA_IN;
    assign pin_raw.addr = DRAM_ADDR_IN;

    pin_sync #(
        .WIDTH($bits(sdram_mode_pkg::dram_cmd_t) + 1)
    ) u_sync (
        .clk(CLK_IN),
        .resetn(RESETN_IN),
        .d({DRAM_CK_IN, pin_raw}),
        .q({ck_sync, pin})
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sdram_mode_pkg::mode_state_t st;
    sdram_mode_pkg::mode_state_t next_st;

    logic ck_rise;
    logic [4:0] cl;
    logic [4:0] write_cas_latency;
    logic [4:0] al;
    logic [4:0] rd_start;
    logic [31:0] status_word;
    logic bus_setup;
    logic bus_write;

    assign ck_rise = ck_sync && !st.ck_prev;
    assign bus_setup = PSEL_IN && !PENABLE_IN;
    assign bus_write = PSEL_IN && PENABLE_IN && PWRITE_IN && st.pready;

    // ----------------------------------------------------------------
    // Latency decode
    // ----------------------------------------------------------------
    always_comb
    begin
        cl = `CL_BASE + {2'b00, st.mr0[6:4]};
        write_cas_latency = `CWL_BASE + {2'b00, st.mr2[`MR2_CWL_LO +: 3]};
        if (st.mr1[`MR1_DLL_OFF])
        begin
            cl = `DLL_OFF_CAS;
            write_cas_latency = `DLL_OFF_CAS;
        end
        case (st.mr1[`MR1_AL_LO +: 2])
            2'b01: al = cl - 5'h01;
            2'b10: al = cl - 5'h02;
            default: al = 5'h00;
        endcase
        if (st.mr1[`MR1_DLL_OFF])
        begin
            rd_start = al + cl - 5'h01;
        end
        else
        begin
            rd_start = al + cl;
        end
    end

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[0] = !st.mr1[`MR1_DLL_OFF];
        status_word[1] = st.mr3[`MR3_CAL_EN];
        status_word[2] = st.partial_array_self_refresh_lost;
        status_word[3] = st.in_self_refresh;
        status_word[8 +: 5] = al + write_cas_latency;
        status_word[16 +: 5] = al + cl;
        status_word[24 +: 2] = st.rd_state;
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.ck_prev = ck_sync;

        // Commands are taken on DRAM clock rising edges
        if (ck_rise)
        begin
            if (pin.cs_n)
            begin
                next_st.rd_state = st.rd_state;
            end
            else if (pin.ras_n && pin.cas_n && pin.we_n)
            begin
                next_st.rd_state = st.rd_state;
            end
            else if (is_mode_set(pin, 2'b00))
            begin
                next_st.mr0 = pin.addr;
            end
            else if (is_mode_set(pin, 2'b01))
            begin
                next_st.mr1 = pin.addr;
            end
            else if (is_mode_set(pin, 2'b10))
            begin
                next_st.mr2 = pin.addr;
            end
            else if (is_mode_set(pin, 2'b11))
            begin
                next_st.mr3 = pin.addr;
            end
            else if (is_read(pin))
            begin
                next_st.rd_state = sdram_mode_pkg::RD_WAIT;
                next_st.rd_cnt = rd_start;
            end
            // partial array data lost on entry
            else if (is_sr_entry(pin))
            begin
                next_st.in_self_refresh = 1'b1;
                if (st.mr2[2:0] != 3'b000)
                begin
                    next_st.partial_array_self_refresh_lost = 1'b1;
                end
            end

            if (pin.cke && st.in_self_refresh)
            begin
                next_st.in_self_refresh = 1'b0;
            end

            // Read strobe window sequencer
            case (st.rd_state)
                sdram_mode_pkg::RD_IDLE:
                begin
                    next_st.rd_cnt = next_st.rd_cnt;
                end
                sdram_mode_pkg::RD_WAIT:
                begin
                    if (!is_read(pin) || pin.cs_n)
                    begin
                        if (st.rd_cnt <= 5'h01)
                        begin
                            next_st.rd_state = sdram_mode_pkg::RD_BURST;
                            next_st.rd_cnt = 5'(BURST_CK);
                        end
                        else
                        begin
                            next_st.rd_cnt = st.rd_cnt - 5'h01;
                        end
                    end
                end
                sdram_mode_pkg::RD_BURST:
                begin
                    if (!is_read(pin) || pin.cs_n)
                    begin
                        if (st.rd_cnt <= 5'h01)
                        begin
                            next_st.rd_state = sdram_mode_pkg::RD_IDLE;
                            next_st.rd_cnt = 5'h00;
                        end
                        else
                        begin
                            next_st.rd_cnt = st.rd_cnt - 5'h01;
                        end
                    end
                end
                default:
                begin
                    next_st.rd_state = sdram_mode_pkg::RD_IDLE;
                    next_st.rd_cnt = 5'h00;
                end
            endcase
        end

        // APB register writes
        if (bus_write)
        begin
            case (PADDR_IN)
                `OFS_CTRL:
                begin
                    next_st.sensor_hot = PWDATA_IN[`CTRL_HOT];
                    // Hardware set wins over a clear in the same cycle
                    if (PWDATA_IN[`CTRL_CLR_LOST]
                        && !(ck_rise && is_sr_entry(pin) && st.mr2[2:0] != 3'b000))
                    begin
                        next_st.partial_array_self_refresh_lost = 1'b0;
                    end
                end
                `OFS_PATTERN:
                begin
                    next_st.pattern = PWDATA_IN[15:0];
                end
                default:
                begin
                    next_st.pattern = next_st.pattern;
                end
            endcase
        end

        // APB answer registered in the setup cycle
        next_st.pready = bus_setup;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        if (bus_setup)
        begin
            case (PADDR_IN)
                `OFS_MODE0: next_st.prdata = {19'h00000, st.mr0};
                `OFS_MODE1: next_st.prdata = {19'h00000, st.mr1};
                `OFS_MODE2: next_st.prdata = {19'h00000, st.mr2};
                `OFS_MODE3: next_st.prdata = {19'h00000, st.mr3};
                `OFS_STATUS: next_st.prdata = status_word;
                `OFS_CTRL: next_st.prdata = {31'h00000000, st.sensor_hot};
                `OFS_PATTERN: next_st.prdata = {16'h0000, st.pattern};
                default: next_st.pslverr = 1'b1;
            endcase
        end

        // Registered data path controls
        // output disable
        next_st.drv_en = st.rd_state == sdram_mode_pkg::RD_BURST && !st.mr1[`MR1_QOFF];
        next_st.pattern_sel = st.mr3[`MR3_CAL_EN];
        if (st.mr3[`MR3_CAL_EN] && st.rd_state == sdram_mode_pkg::RD_BURST
            && !st.mr1[`MR1_QOFF])
        begin
            next_st.dq = st.pattern;
        end
        else
        begin
            next_st.dq = 16'h0000;
        end
        next_st.cal_loc = st.mr3[`MR3_CAL_EN] ? st.mr3[1:0] : 2'b00;
        next_st.dyn_term = st.mr2[`MR2_RTT_WR_LO +: 2] != 2'b00 && !st.mr1[`MR1_WLEVEL];
        next_st.sr_ext_rate = st.mr2[`MR2_ASR] ? st.sensor_hot : st.mr2[`MR2_SRT];
        next_st.dll_enable = !st.mr1[`MR1_DLL_OFF];
        next_st.write_latency = al + write_cas_latency;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            st <= '0;
            st.mr0 <= `MODE_RESET;
            st.mr1 <= `MODE_RESET;
            st.mr2 <= `MODE_RESET;
            st.mr3 <= `MODE_RESET;
            st.pattern <= `PATTERN_RESET;
            st.dll_enable <= 1'b1;
            st.write_latency <= `CWL_BASE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign PRDATA_OUT = st.prdata;
    assign PREADY_OUT = st.pready;
    assign PSLVERR_OUT = st.pslverr;
    assign DRV_EN_OUT = st.drv_en;
    assign DQ_OUT = st.dq;
    assign PATTERN_SEL_OUT = st.pattern_sel;
    assign CAL_LOC_OUT = st.cal_loc;
    assign DYN_TERM_EN_OUT = st.dyn_term;
    assign SR_EXT_RATE_OUT = st.sr_ext_rate;
    assign DLL_ENABLE_OUT = st.dll_enable;
    assign WRITE_LATENCY_OUT = st.write_latency;

endmodule

// File: verilog/sdram_mode_consts.svh
// Offsets, field positions, reset values and timing counts of the mode block
`ifndef SDRAM_MODE_CONSTS_SVH
`define SDRAM_MODE_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_MODE0 8'h00
`define OFS_MODE1 8'h04
`define OFS_MODE2 8'h08
`define OFS_MODE3 8'h0c
`define OFS_STATUS 8'h10
`define OFS_CTRL 8'h14
`define OFS_PATTERN 8'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MR1_DLL_OFF 0
`define MR1_AL_LO 3
`define MR1_WLEVEL 7
`define MR1_QOFF 12
`define MR2_CWL_LO 3
`define MR2_ASR 6
`define MR2_SRT 7
`define MR2_RTT_WR_LO 9
`define MR3_CAL_EN 2
`define CTRL_HOT 0
`define CTRL_CLR_LOST 1

// ----------------------------------------------------------------
// Reset values and timing counts
// ----------------------------------------------------------------
`define MODE_RESET 13'h0000
`define PATTERN_RESET 16'h5555
`define DLL_OFF_CAS 5'h06
`define CL_BASE 5'h04
`define CWL_BASE 5'h05
`define BURST_CK 3'h4

`endif

// File: verilog/sdram_mode_pkg.sv
// Types shared by the mode register block
package sdram_mode_pkg;

    // Command pins sampled at the DRAM clock
    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [12:0] addr;
    } dram_cmd_t;

    // Read strobe window sequencer, one bit changes per step except RD_BURST to RD_IDLE
    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_WAIT = 2'b01,
        RD_BURST = 2'b11
    } rd_state_t;

    // Whole state of the block
    typedef struct packed {
        logic ck_prev;
        logic [12:0] mr0;
        logic [12:0] mr1;
        logic [12:0] mr2;
        logic [12:0] mr3;
        rd_state_t rd_state;
        logic [4:0] rd_cnt;
        logic partial_array_self_refresh_lost;
        logic in_self_refresh;
        logic sensor_hot;
        logic [15:0] pattern;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic drv_en;
        logic [15:0] dq;
        logic pattern_sel;
        logic dyn_term;
        logic sr_ext_rate;
        logic dll_enable;
        logic [4:0] write_latency;
        logic [1:0] cal_loc;
    } mode_state_t;

endpackage

// File: verilog/pin_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    if (WIDTH < 1)
    begin : g_width_check
        $error("pin_sync WIDTH must be at least 1");
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// File: bench/sdram_mode_ctrl_asserts.sv
// Port-level assertions for the mode register block
module sdram_mode_ctrl_asserts #(
    parameter int BURST_CK = 4
) (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // Command pins
    input wire logic DRAM_CS_N_IN,
    input wire logic DRAM_RAS_N_IN,
    input wire logic DRAM_CAS_N_IN,
    input wire logic DRAM_WE_N_IN,
    // APB
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    // Data path controls
    input wire logic DRV_EN_OUT,
    input wire logic [15:0] DQ_OUT,
    input wire logic PATTERN_SEL_OUT,
    input wire logic [1:0] CAL_LOC_OUT,
    input wire logic DLL_ENABLE_OUT,
    input wire logic [4:0] WRITE_LATENCY_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] run;
    default clocking dc @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);
    // Length of the current drive window
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
            run <= 8'h00;
        else if (DRV_EN_OUT)
            run <= run + 8'h01;
        else
            run <= 8'h00;
    end
    chk_loc_gated: assert property (!PATTERN_SEL_OUT |-> CAL_LOC_OUT == 2'h0)
        else $error("location select seen with pattern off");
    chk_dq_array: assert property (DRV_EN_OUT && !PATTERN_SEL_OUT |-> DQ_OUT == 16'h0000)
        else $error("data seen with pattern off");
    chk_dq_off: assert property (!DRV_EN_OUT |-> DQ_OUT == 16'h0000)
        else $error("data driven outside window");
    chk_dll_off_wl: assert property (!DLL_ENABLE_OUT |-> WRITE_LATENCY_OUT inside {5'h06, 5'h0a, 5'h0b})
        else $error("write latency off the DLL-off set");
    chk_window_len: assert property ($fell(DRV_EN_OUT) |-> run >= 8 * BURST_CK - 4 && run <= 8 * BURST_CK + 4)
        else $error("read window length wrong");
    chk_apb_ready: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
        else $error("ready not a single pulse after setup");
    chk_err_ready: assert property (PSLVERR_OUT |-> PREADY_OUT)
        else $error("error without ready");
    chk_deselect_hold: assert property (DRAM_CS_N_IN [*8] |-> $stable(DLL_ENABLE_OUT) && $stable(WRITE_LATENCY_OUT) && $stable(PATTERN_SEL_OUT))
        else $error("mode outputs moved while deselected");
    chk_nop_hold: assert property ((!DRAM_CS_N_IN && DRAM_RAS_N_IN && DRAM_CAS_N_IN && DRAM_WE_N_IN) [*8] |-> $stable(DLL_ENABLE_OUT) && $stable(WRITE_LATENCY_OUT) && $stable(PATTERN_SEL_OUT))
        else $error("mode outputs moved during no operation");
endmodule

bind sdram_mode_ctrl sdram_mode_ctrl_asserts #(.BURST_CK(BURST_CK)) sdram_mode_ctrl_asserts_i (
    .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .DRAM_CS_N_IN(DRAM_CS_N_IN),
    .DRAM_RAS_N_IN(DRAM_RAS_N_IN), .DRAM_CAS_N_IN(DRAM_CAS_N_IN), .DRAM_WE_N_IN(DRAM_WE_N_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .DRV_EN_OUT(DRV_EN_OUT), .DQ_OUT(DQ_OUT),
    .PATTERN_SEL_OUT(PATTERN_SEL_OUT), .CAL_LOC_OUT(CAL_LOC_OUT),
    .DLL_ENABLE_OUT(DLL_ENABLE_OUT), .WRITE_LATENCY_OUT(WRITE_LATENCY_OUT));

// File: bench/dram_ctrl_model.sv
// Memory controller model: DRAM clock and command pins
module dram_ctrl_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Command request
    input wire logic req_in,
    input sdram_mode_pkg::dram_cmd_t cmd_in,
    output logic ack_out,
    // Pins
    output logic ck_out,
    output sdram_mode_pkg::dram_cmd_t pins_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt;
    sdram_mode_pkg::dram_cmd_t c;
    assign ck_out = cnt[2];
    always @(posedge clk or negedge resetn)
    begin
        c = cmd_in;
        if (!c.ras_n && !c.cas_n && !c.we_n)
        begin
            c.ba[2] = 1'b0;
            if (c.ba == 3'h2)
                c.addr = c.addr & 13'h06ff;
            if (c.ba == 3'h3)
                c.addr = c.addr & 13'h0007;
        end
        if (!resetn)
        begin
            cnt <= 3'h0;
            ack_out <= 1'b0;
            pins_out <= {5'h1f, 16'h0000};
        end
        else
        begin
            cnt <= cnt + 3'h1;
            ack_out <= (cnt == 3'h7) && req_in;
            if (cnt == 3'h7)
                pins_out <= req_in ? c : {5'h1f, 3'h0, ~pins_out.addr};
        end
    end
endmodule

// File: bench/test_sdram_mode_ctrl.sv
// Self-checking bench for the mode register block
module test_sdram_mode_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MOD_CK = 12;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic req = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] seed = 32'd67293;
    logic ack, dck, pready, pslverr, drv_en, pat_sel, dyn_term, sr_ext, dll_en, er;
    logic [31:0] prdata, rd, v;
    logic [15:0] dq;
    logic [1:0] cal_loc;
    logic [4:0] wl;
    sdram_mode_pkg::dram_cmd_t cmd = '0;
    sdram_mode_pkg::dram_cmd_t pins;
    int err_total = 0;
    int check_count = 0;
    int hot = 0;
    int mr[4] = '{0, 0, 0, 0};
    initial
    begin
        forever #25 clk = ~clk;
    end
    dram_ctrl_model dram_ctrl_model_i (.clk(clk), .resetn(resetn), .req_in(req), .cmd_in(cmd),
        .ack_out(ack), .ck_out(dck), .pins_out(pins));
    sdram_mode_ctrl sdram_mode_ctrl_i (.CLK_IN(clk), .RESETN_IN(resetn), .DRAM_CK_IN(dck),
        .DRAM_CKE_IN(pins.cke), .DRAM_CS_N_IN(pins.cs_n), .DRAM_RAS_N_IN(pins.ras_n),
        .DRAM_CAS_N_IN(pins.cas_n), .DRAM_WE_N_IN(pins.we_n), .DRAM_BA_IN(pins.ba),
        .DRAM_ADDR_IN(pins.addr), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .DRV_EN_OUT(drv_en), .DQ_OUT(dq), .PATTERN_SEL_OUT(pat_sel),
        .CAL_LOC_OUT(cal_loc), .DYN_TERM_EN_OUT(dyn_term), .SR_EXT_RATE_OUT(sr_ext),
        .DLL_ENABLE_OUT(dll_en), .WRITE_LATENCY_OUT(wl));
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int cl();
        return mr[1][0] ? 6 : 4 + ((mr[0] >> 4) & 7);
    endfunction
    function automatic int al();
        int code;
        code = (mr[1] >> 3) & 3;
        return code == 1 ? cl() - 1 : (code == 2 ? cl() - 2 : 0);
    endfunction
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) err_total++;
    endtask
    task automatic dram(logic [4:0] ctl, logic [2:0] ba, logic [12:0] a);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        cmd <= {ctl, ba, a};
        do
            @(posedge clk);
        while (ack !== 1'b1 && ++n < 20);
        req <= 1'b0;
        if (n >= 20) err_total++;
    endtask
    task automatic cmp_out();
        chk("dll_enable", !mr[1][0], dll_en);
        chk("write_latency", al() + (mr[1][0] ? 6 : 5 + ((mr[2] >> 3) & 7)), wl);
        chk("pattern_sel", mr[3][2], pat_sel);
        chk("cal_loc", mr[3][2] ? mr[3] & 3 : 0, cal_loc);
        chk("dyn_term", ((mr[2] >> 9) & 3) != 0 && !mr[1][7], dyn_term);
        chk("sr_ext_rate", mr[2][6] ? hot : mr[2][7], sr_ext);
        for (int r = 0; r < 4; r++)
        begin
            apb(1'b0, 8'(r * 4), 32'h0);
            chk("mode_reg", mr[r], rd);
        end
    endtask
    task automatic mrs(int r, int val);
        mr[r] = val;
        dram(5'h10, 3'(r), 13'(val));
        repeat (10) @(posedge clk);
        cmp_out();
    endtask
    task automatic read_win(int start, logic drv, logic [15:0] pat);
        int n, st;
        logic pr;
        n = 0;
        st = -1;
        pr = dck;
        dram(5'h15, 3'h0, 13'h0000);
        repeat (8 * (start + 8))
        begin
            @(posedge clk);
            if (dck && !pr) n++;
            pr = dck;
            if (drv_en === 1'b1 && st < 0)
            begin
                st = n;
                chk("read_data", pat, dq);
            end
        end
        chk("read_start", drv ? start + 1 : -1, st);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (40000) @(posedge clk);
        err_total++;
        complete_run();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        cmp_out();
        apb(1'b0, 8'h18, 32'h0);
        chk("pattern_reset", 32'h5555, rd);
        apb(1'b1, 8'h1c, 32'hffffffff);
        chk("unmapped_err", 32'h1, er);
        for (int i = 0; i < 8; i++)
        begin
            mrs(0, xs() & 32'h70);
            mrs(2, xs() & 32'h6f8);
            hot = xs() & 1;
            apb(1'b1, 8'h14, hot);
            mrs(1, ((i & 3) << 3) | ((i >> 2) << 7));
        end
        for (int i = 0; i < 8; i++)
        begin
            // precharge first, leave pattern mode by mode set
            if (i > 3) dram(5'h12, 3'h0, 13'h0400);
            mrs(3, i);
            if (i > 3) mrs(3, 0);
        end
        dram(5'h18, 3'h2, 13'h1fff);
        dram(5'h17, 3'h3, 13'(xs()));
        repeat (10) @(posedge clk);
        cmp_out();
        mrs(0, 0);
        mrs(2, 0);
        mrs(1, 32'h8);
        read_win(7, 1'b1, 16'h0000);
        v = xs();
        apb(1'b1, 8'h18, v);
        dram(5'h12, 3'h0, 13'h0400);
        mrs(3, 4);
        read_win(7, 1'b1, v[15:0]);
        mrs(3, 0);
        mrs(1, 32'h1008);
        read_win(7, 1'b0, 16'h0000);
        mrs(2, 1);
        // DLL off, wait, then self refresh
        mrs(1, 32'h9);
        repeat (8 * MOD_CK) @(posedge clk);
        dram(5'h01, 3'h0, 13'h0000);
        repeat (8 * MOD_CK) @(posedge clk);
        apb(1'b0, 8'h10, 32'h0);
        chk("partial_array_self_refresh_lost", 32'h1, (rd >> 2) & 1);
        apb(1'b1, 8'h14, 32'h2 | hot);
        apb(1'b0, 8'h10, 32'h0);
        chk("partial_array_self_refresh_clear", 32'h0, (rd >> 2) & 1);
        mrs(2, 32'h8);
        read_win(10, 1'b1, 16'h0000);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        mr = '{0, 0, 0, 0};
        hot = 0;
        cmp_out();
        complete_run();
    end
endmodule
